// ---- core/cwc_pkg.sv ----
// Constants, register map and state layout of the counter window compare unit
// Assumes a 32-bit AXI4-Lite master and a pulse counter on the same clock
package cwc_pkg;
	localparam int unsigned CWC_CHANNELS   = 7;
	localparam int unsigned CWC_ADDR_W     = 8;
	localparam logic [7:0]  CWC_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  CWC_OFF_LOW    = 8'h04;
	localparam logic [7:0]  CWC_OFF_HIGH   = 8'h08;
	localparam logic [7:0]  CWC_OFF_SET    = 8'h0c;
	localparam logic [7:0]  CWC_OFF_STATUS = 8'h10;
	localparam logic [7:0]  CWC_OFF_ISTAT  = 8'h14;
	localparam logic [7:0]  CWC_OFF_IMASK  = 8'h18;
	localparam logic [7:0]  CWC_OFF_COUNT  = 8'h1c;
	localparam int unsigned CWC_CTRL_EN    = 0;
	localparam int unsigned CWC_CTRL_PERM  = 1;
	localparam int unsigned CWC_CTRL_INTEN = 2;
	localparam int unsigned CWC_CTRL_SEL   = 4;
	localparam int unsigned CWC_ST_STATUS  = 0;
	localparam int unsigned CWC_ST_VALID   = 1;
	localparam int unsigned CWC_ST_HIT     = 2;
	localparam int unsigned CWC_ST_ERR     = 3;
	localparam int unsigned CWC_ST_CODE    = 16;
	localparam int unsigned CWC_IRQ_MATCH  = 0;
	localparam int unsigned CWC_IRQ_WIN    = 1;
	localparam logic [31:0] CWC_LOW_RST    = 32'h0000_0000;
	localparam logic [31:0] CWC_HIGH_RST   = 32'h0000_0000;
	localparam logic [31:0] CWC_SET_RST    = 32'h0000_0000;
	localparam logic [1:0]  CWC_MASK_RST   = 2'h0;
	localparam logic [15:0] CWC_ERR_CODE   = 16'h0000;
	localparam logic [1:0]  CWC_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  CWC_RESP_SLV   = 2'h2;

	typedef struct packed {
		logic        aw_ready;
		logic        w_ready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        b_valid;
		logic [1:0]  b_resp;
		logic        ar_ready;
		logic        r_valid;
		logic [1:0]  r_resp;
		logic [31:0] r_data;
		logic        enable;
		logic        permit;
		logic        int_en;
		logic        int_en_prev;
		logic        armed;
		logic [2:0]  sel;
		logic [31:0] low;
		logic [31:0] high;
		logic [31:0] set_val;
		logic [31:0] prev_count;
		logic [1:0]  ist;
		logic [1:0]  mask;
		logic        status;
		logic        valid;
		logic        hit;
		logic [6:0]  line;
		logic        err;
		logic [15:0] err_code;
		logic        irq;
	} cwc_state_t;
endpackage

// ---- core/cwc_window_compare.sv ----
// Counter window compare unit with AXI4-Lite register slave and interrupt
// Assumes counter_value comes from counter logic clocked by ref_clk
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns

// How it works
// - Seven channels; channel n drives output line n.
// - Status and valid rise one cycle after enable rises.
// - Status and valid fall one cycle after enable falls.
// - Valid plus permit plus condition sets hit flag and line; both clear automatically.
// - Condition holds while the count lies within low and high bounds inclusive.
// - Window is checked in hardware every clock, not by software polling.
// - Once armed by an interrupt enable rise, each arrival at set value sets match status; irq rises only if its mask bit is set.
module cwc_window_compare
	import cwc_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic [CWC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [CWC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [6:0][31:0]      counter_value,
	output logic [6:0]                 compare_output_line,
	output logic                       window_hit,
	output logic                       status,
	output logic                       valid,
	output logic                       error_flag,
	output logic [15:0]                error_code,
	output logic                       irq
);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	cwc_state_t         s_q;
	cwc_state_t         s_d;
	logic               sel_ok;
	logic signed [31:0] cur;
	logic               in_win;
	logic               hit_cond;
	logic               evt_match;
	logic [1:0]         events;
	logic [1:0]         rd_clr;
	logic [31:0]        ctrl_word;
	logic [31:0]        mask_word;

	always_comb
	begin
		s_d = s_q;
		rd_clr = 2'h0;
		mask_word = 32'h0;
		sel_ok = (s_q.sel < 3'(CWC_CHANNELS));
		cur = sel_ok ? counter_value[s_q.sel] : 32'sh0;
		// Signed compare so a negative count never falls into a positive window
		in_win = sel_ok && (cur >= $signed(s_q.low)) && (cur <= $signed(s_q.high));
		hit_cond = s_q.valid && s_q.permit && in_win;
		ctrl_word = 32'h0;
		ctrl_word[CWC_CTRL_EN] = s_q.enable;
		ctrl_word[CWC_CTRL_PERM] = s_q.permit;
		ctrl_word[CWC_CTRL_INTEN] = s_q.int_en;
		ctrl_word[CWC_CTRL_SEL +: 3] = s_q.sel;

		// Status and valid follow enable by one cycle
		s_d.status = s_q.enable;
		s_d.valid = s_q.enable;
		s_d.hit = hit_cond;
		s_d.line = 7'h00;
		if (hit_cond)
			s_d.line[s_q.sel] = 1'b1;
		s_d.err = 1'b0;
		s_d.err_code = CWC_ERR_CODE;

		// Arming needs a rising edge of the interrupt function enable
		s_d.int_en_prev = s_q.int_en;
		if (!s_q.int_en)
			s_d.armed = 1'b0;
		else if (!s_q.int_en_prev)
			s_d.armed = 1'b1;
		s_d.prev_count = cur;
		// Edge on equality so a count that rests at the set value fires once
		evt_match = s_q.armed && (cur == $signed(s_q.set_val)) && (s_q.prev_count != s_q.set_val);
		events = 2'h0;
		events[CWC_IRQ_MATCH] = evt_match;
		events[CWC_IRQ_WIN] = hit_cond && !s_q.hit;

		// Write channel
		if (s_axi_awvalid && s_q.aw_ready)
		begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.w_ready)
		begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.b_valid && s_axi_bready)
			s_d.b_valid = 1'b0;
		if (s_d.aw_got && s_d.w_got && !s_q.b_valid)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.b_valid = 1'b1;
			s_d.b_resp = CWC_RESP_OKAY;
			case (s_d.aw_addr)
				CWC_OFF_CTRL:
				begin
					ctrl_word = merge_bytes(ctrl_word, s_d.w_data, s_d.w_strb);
					s_d.enable = ctrl_word[CWC_CTRL_EN];
					s_d.permit = ctrl_word[CWC_CTRL_PERM];
					s_d.int_en = ctrl_word[CWC_CTRL_INTEN];
					s_d.sel = ctrl_word[CWC_CTRL_SEL +: 3];
				end
				CWC_OFF_LOW:    s_d.low = merge_bytes(s_q.low, s_d.w_data, s_d.w_strb);
				CWC_OFF_HIGH:   s_d.high = merge_bytes(s_q.high, s_d.w_data, s_d.w_strb);
				CWC_OFF_SET:    s_d.set_val = merge_bytes(s_q.set_val, s_d.w_data, s_d.w_strb);
				CWC_OFF_IMASK:
				begin
					mask_word = merge_bytes({30'h0, s_q.mask}, s_d.w_data, s_d.w_strb);
					s_d.mask = mask_word[1:0];
				end
				CWC_OFF_STATUS, CWC_OFF_ISTAT, CWC_OFF_COUNT:
					s_d.b_resp = CWC_RESP_OKAY;
				default:        s_d.b_resp = CWC_RESP_SLV;
			endcase
		end
		s_d.aw_ready = !s_d.aw_got && !s_d.b_valid;
		s_d.w_ready = !s_d.w_got && !s_d.b_valid;

		// Read channel
		if (s_q.r_valid && s_axi_rready)
			s_d.r_valid = 1'b0;
		if (s_axi_arvalid && s_q.ar_ready)
		begin
			s_d.r_valid = 1'b1;
			s_d.r_resp = CWC_RESP_OKAY;
			s_d.r_data = 32'h0;
			case (s_axi_araddr)
				CWC_OFF_CTRL:   s_d.r_data = ctrl_word;
				CWC_OFF_LOW:    s_d.r_data = s_q.low;
				CWC_OFF_HIGH:   s_d.r_data = s_q.high;
				CWC_OFF_SET:    s_d.r_data = s_q.set_val;
				CWC_OFF_STATUS:
				begin
					s_d.r_data[CWC_ST_STATUS] = s_q.status;
					s_d.r_data[CWC_ST_VALID] = s_q.valid;
					s_d.r_data[CWC_ST_HIT] = s_q.hit;
					s_d.r_data[CWC_ST_ERR] = s_q.err;
					s_d.r_data[CWC_ST_CODE +: 16] = s_q.err_code;
				end
				CWC_OFF_ISTAT:
				begin
					s_d.r_data[1:0] = s_q.ist;
					rd_clr = s_q.ist;
				end
				CWC_OFF_IMASK:  s_d.r_data[1:0] = s_q.mask;
				CWC_OFF_COUNT:  s_d.r_data = cur;
				default:        s_d.r_resp = CWC_RESP_SLV;
			endcase
		end
		s_d.ar_ready = !s_d.r_valid;

		// Read clears only what was returned; a new event in the same cycle survives
		s_d.ist = (s_q.ist & ~rd_clr) | events;
		s_d.irq = |(s_d.ist & s_d.mask);
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q <= '0;
			s_q.low <= CWC_LOW_RST;
			s_q.high <= CWC_HIGH_RST;
			s_q.set_val <= CWC_SET_RST;
			s_q.mask <= CWC_MASK_RST;
			s_q.err_code <= CWC_ERR_CODE;
		end
		else
			s_q <= s_d;
	end

	assign s_axi_awready = s_q.aw_ready;
	assign s_axi_wready = s_q.w_ready;
	assign s_axi_bvalid = s_q.b_valid;
	assign s_axi_bresp = s_q.b_resp;
	assign s_axi_arready = s_q.ar_ready;
	assign s_axi_rvalid = s_q.r_valid;
	assign s_axi_rdata = s_q.r_data;
	assign s_axi_rresp = s_q.r_resp;
	assign compare_output_line = s_q.line;
	assign window_hit = s_q.hit;
	assign status = s_q.status;
	assign valid = s_q.valid;
	assign error_flag = s_q.err;
	assign error_code = s_q.err_code;
	assign irq = s_q.irq;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_enable_rise_status: assert property ($rose(s_q.enable) |=> status && valid)
		else $error("status or valid missed enable rise");
	a_enable_fall_status: assert property ($fell(s_q.enable) |=> !status ##0 !valid)
		else $error("status or valid missed enable fall");
	a_line_per_channel: assert property (hit_cond |=> compare_output_line == (7'h01 << $past(s_q.sel)))
		else $error("wrong compare line driven");
	a_hit_matches_line: assert property (window_hit == (compare_output_line != 7'h00))
		else $error("hit flag and line disagree");
	a_hit_auto_clear: assert property (!(s_q.permit && in_win) |=> !window_hit && compare_output_line == 7'h00)
		else $error("hit not cleared when condition lost");
	a_window_bounds: assert property ((s_q.valid && s_q.permit && sel_ok && cur >= $signed(s_q.low)
		&& cur <= $signed(s_q.high)) |=> window_hit)
		else $error("count inside bounds without hit");
	a_match_irq_set: assert property ((s_q.armed && cur == $signed(s_q.set_val)
		&& s_q.prev_count != s_q.set_val) |=> s_q.ist[CWC_IRQ_MATCH])
		else $error("count match did not set status");
	a_match_unarmed: assert property (!s_q.armed && !$past(s_q.armed) |-> !$rose(s_q.ist[CWC_IRQ_MATCH]))
		else $error("match status set while not armed");
	a_error_reserved: assert property (!error_flag && error_code == 16'h0000)
		else $error("reserved error outputs not zero");

	a_line_onehot: assert property ($onehot0(compare_output_line)
		&& (compare_output_line == 7'h00 || window_hit))
		else $error("more than one compare line driven");

	a_line_no_channel: assert property (s_q.sel == 3'h7
		|=> compare_output_line == 7'h00)
		else $error("line driven with no channel selected");

	a_line_selected: assert property (compare_output_line != 7'h00
		|-> compare_output_line == (7'h01 << $past(s_q.sel)))
		else $error("line of an unselected channel driven");

	a_status_pair: assert property (status == valid
		&& valid == s_q.valid)
		else $error("status and valid disagree");

	a_status_follows: assert property (status
		== $past(s_q.enable))
		else $error("status not one cycle behind enable");

	a_rise_after_enable: assert property ($rose(status)
		|-> $past(s_q.enable))
		else $error("status rose without enable");

	a_fall_after_enable: assert property ($fell(status)
		|-> !$past(s_q.enable))
		else $error("status fell while enabled");

	a_fall_no_hit: assert property ($fell(valid)
		|=> !window_hit)
		else $error("hit kept after disable");

	a_disabled_silent: assert property (!s_q.valid
		|=> !window_hit && compare_output_line == 7'h00)
		else $error("output driven while not valid");

	a_hit_needs_permit: assert property (!s_q.permit
		|=> !window_hit)
		else $error("hit without output permit");

	a_hit_follows_cond: assert property (window_hit
		== $past(hit_cond))
		else $error("hit not one cycle behind condition");

	a_hit_rise_window: assert property ($rose(window_hit)
		|-> $past(in_win) && $past(s_q.permit))
		else $error("hit rose outside window");

	a_below_low: assert property (sel_ok && cur < $signed(s_q.low)
		|=> !window_hit)
		else $error("hit below low bound");

	a_above_high: assert property (sel_ok && cur > $signed(s_q.high)
		|=> !window_hit)
		else $error("hit above high bound");

	a_empty_window: assert property ($signed(s_q.high) < $signed(s_q.low)
		|=> !window_hit)
		else $error("hit with empty window");

	a_unselected_no_hit: assert property (!sel_ok
		|=> !window_hit)
		else $error("hit with no channel");

	a_entry_flagged: assert property (hit_cond && !s_q.hit
		|=> s_q.ist[CWC_IRQ_WIN])
		else $error("window entry not recorded");

	a_arm_on_edge: assert property ($rose(s_q.armed)
		|-> $past(s_q.int_en) && !$past(s_q.int_en_prev))
		else $error("armed without enable edge");

	a_disarm: assert property (!s_q.int_en
		|=> !s_q.armed)
		else $error("still armed after interrupt disable");

	a_match_from_event: assert property ($rose(s_q.ist[CWC_IRQ_MATCH])
		|-> $past(evt_match))
		else $error("match status set without event");

	a_match_sticky: assert property (s_q.ist[CWC_IRQ_MATCH] && !rd_clr[CWC_IRQ_MATCH]
		|=> s_q.ist[CWC_IRQ_MATCH])
		else $error("match status lost without read");

	a_irq_level: assert property (irq
		== |(s_q.ist & s_q.mask))
		else $error("interrupt line disagrees with status");

	a_irq_masked: assert property (s_q.mask == 2'h0
		|-> !irq)
		else $error("interrupt raised while masked");

	a_error_status_bits: assert property (s_q.err == 1'b0
		&& s_q.err_code == CWC_ERR_CODE)
		else $error("reserved error state not zero");
endmodule

// ---- sim/cwc_counter_model.sv ----
// Behavioural model of the seven-channel pulse counter at the far side
// Assumes the bench loads and steps it on ref_clk
`timescale 1ns/1ns
module cwc_counter_model
	import cwc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             load,
	input  wire logic [31:0]      load_val,
	input  wire logic             run,
	output logic      [6:0][31:0] counter_value
);
	logic [31:0] base_q;
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			base_q <= 32'h0;
		else if (load)
			base_q <= load_val;
		else if (run)
			base_q <= base_q + 32'h1;
	end
	// Channels sit far apart, so a wrong select can never land in the window by luck
	always_comb
	begin
		for (int n = 0; n < CWC_CHANNELS; n++)
			counter_value[n] = base_q - 32'(n) * 32'h0000_2000;
	end
endmodule

// ---- sim/counter_window_compare_bench.sv ----
// Self-checking bench of the counter window compare unit
// Assumes the design under core/ and the counter model beside this file
`timescale 1ns/1ns
module counter_window_compare_bench;
	import cwc_pkg::*;
	logic                  ref_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic                  window_hit, status, valid, error_flag, irq, load, run, sb;
	logic [CWC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]           s_axi_wdata, s_axi_rdata, load_val, rd;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
	logic [6:0][31:0]      counter_value;
	logic [6:0]            compare_output_line;
	logic [15:0]           error_code;
	int                    error_cnt, n_compared;

	cwc_counter_model u_cwc_counter_model (.ref_clk(ref_clk), .rst_b(rst_b), .load(load), .load_val(load_val),
		.run(run), .counter_value(counter_value));
	cwc_window_compare u_cwc_window_compare (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .counter_value(counter_value), .compare_output_line(compare_output_line),
		.window_hit(window_hit), .status(status), .valid(valid), .error_flag(error_flag),
		.error_code(error_code), .irq(irq));

	always #4 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Ready is a registered output, so looking at the falling edge predicts the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic at, wt, g;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		g = 1'b0;
		while (!g)
		begin
			@(negedge ref_clk);
			at  = s_axi_awvalid & s_axi_awready;
			wt  = s_axi_wvalid & s_axi_wready;
			g   = s_axi_bvalid;
			rsp = s_axi_bresp;
			sb  = status;
			@(posedge ref_clk);
			if (at)
				s_axi_awvalid <= 1'b0;
			if (wt)
				s_axi_wvalid <= 1'b0;
		end
	endtask

	task automatic rd_reg(input logic [7:0] a);
		logic at, g;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		g = 1'b0;
		while (!g)
		begin
			@(negedge ref_clk);
			at  = s_axi_arvalid & s_axi_arready;
			g   = s_axi_rvalid;
			rd  = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge ref_clk);
			if (at)
				s_axi_arvalid <= 1'b0;
		end
	endtask

	// Loads the count, lets it settle with no bus traffic, then checks the line
	task automatic win(input logic [31:0] v, input logic [6:0] e);
		load_val <= v;
		load     <= 1'b1;
		@(posedge ref_clk);
		load <= 1'b0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(compare_output_line), 32'(e));
		chk(32'(window_hit), 32'(|e));
		@(posedge ref_clk);
	endtask

	task automatic t_regs();
		rd_reg(CWC_OFF_LOW);
		chk(rd, CWC_LOW_RST);
		wr(CWC_OFF_HIGH, 32'h0000_1388);
		rd_reg(CWC_OFF_HIGH);
		chk(rd, 32'h0000_1388);
		rd_reg(8'h20);
		chk(32'(rsp), 32'(CWC_RESP_SLV));
		chk(32'({error_flag, error_code}), 32'h0);
	endtask

	task automatic t_en();
		wr(CWC_OFF_LOW, 32'h0000_03e8);
		wr(CWC_OFF_CTRL, 32'h0000_0003);
		chk(32'(sb), 32'h0);
		@(negedge ref_clk);
		chk(32'({status, valid}), 32'h3);
		@(posedge ref_clk);
		win(32'h0000_03e7, 7'h00);
		win(32'h0000_03e8, 7'h01);
		win(32'h0000_1388, 7'h01);
		win(32'h0000_1389, 7'h00);
	endtask

	task automatic t_sel();
		for (int c = 0; c < 7; c++)
		begin
			wr(CWC_OFF_CTRL, 32'h3 | (32'(c) << CWC_CTRL_SEL));
			win(32'h0000_0bb8 + 32'(c) * 32'h0000_2000, 7'h01 << c);
		end
		wr(CWC_OFF_CTRL, 32'h0000_0001);
		win(32'h0000_0bb8, 7'h00);
		wr(CWC_OFF_CTRL, 32'h0000_0000);
		chk(32'(sb), 32'h1);
		@(negedge ref_clk);
		chk(32'({status, valid}), 32'h0);
		@(posedge ref_clk);
	endtask

	// Third pass has the mask off: the event must still be recorded but stay silent
	task automatic t_irq();
		rd_reg(CWC_OFF_ISTAT);
		wr(CWC_OFF_SET, 32'h0000_1388);
		wr(CWC_OFF_CTRL, 32'h0000_0005);
		for (int i = 0; i < 3; i++)
		begin
			wr(CWC_OFF_IMASK, 32'(i < 2));
			rd_reg(CWC_OFF_IMASK);
			chk(rd, 32'(i < 2));
			run <= 1'b1;
			win(32'h0000_1386, 7'h00);
			run <= 1'b0;
			repeat (2) @(posedge ref_clk);
			@(negedge ref_clk);
			chk(32'(irq), 32'(i < 2));
			@(posedge ref_clk);
			rd_reg(CWC_OFF_ISTAT);
			chk(rd, 32'h0000_0001);
			@(negedge ref_clk);
			chk(32'(irq), 32'h0);
			@(posedge ref_clk);
		end
		rd_reg(CWC_OFF_COUNT);
		chk(rd, 32'h0000_138a);
		rd_reg(CWC_OFF_STATUS);
		chk(rd, 32'h0000_0003);
	endtask

	task automatic finish_test();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		{ref_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, load_val, load, run} = 82'h0;
		s_axi_wstrb = 4'hf;
		error_cnt = 0;
		n_compared = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Response ready stays high all run, so back-to-back calls never retoggle it
		s_axi_bready <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_regs();
		t_en();
		t_sel();
		t_irq();
		finish_test();
	end

	// Under two hundred cycles are needed; far more means a handshake hung
	initial
	begin
		#200000;
		error_cnt++;
		finish_test();
	end
endmodule
